// File: uhi_defs.svh
// register offsets, field positions, reset values and timing counts for one serial channel
`ifndef UHI_DEFS_SVH
`define UHI_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UHI_OFS_HOLD 3'h0
`define UHI_OFS_MASK 3'h1
`define UHI_OFS_SRC_FCTL 3'h2
`define UHI_OFS_LCTL 3'h3
`define UHI_OFS_LSTAT 3'h5
`define UHI_OFS_MSTAT 3'h6
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define UHI_LCR_DLE 7
`define UHI_FCR_EN 0
`define UHI_FCR_RXRST 1
`define UHI_FCR_TXRST 2
`define UHI_FCR_DMA 3
`define UHI_MASK_RST 4'h0
`define UHI_LCR_RST 8'h00
// ----------------------------------------
// interrupt source codes
// ----------------------------------------
`define UHI_SRC_NONE 4'h1
`define UHI_SRC_LINE 4'h6
`define UHI_SRC_RX_READY_IRQ 4'h4
`define UHI_SRC_TXEMPTY 4'h2
`define UHI_SRC_MODEM 4'h0
// ----------------------------------------
// timing and trigger levels
// ----------------------------------------
`define UHI_OVERSAMPLE 16
`define UHI_MID_TICK 4'h7
`define UHI_LAST_TICK 4'hF
`define UHI_TRIG0 8'h01
`define UHI_TRIG1 8'h04
`define UHI_TRIG2 8'h08
`define UHI_TRIG3 8'h0E
`endif

// File: uhi_pkg.sv
// types shared by the serial channel
package uhi_pkg;
  // host access carried as one bundle
  typedef struct packed {
    logic cs_n;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uhi_bus_req_t;
  // one queued receive character with its error marks
  typedef struct packed {
    logic brk;
    logic frm;
    logic [7:0] data;
  } uhi_rx_entry_t;
  // serial engine phases, shared by both directions
  typedef enum logic [3:0] {
    SER_IDLE = 4'h1,
    SER_START = 4'h2,
    SER_DATA = 4'h4,
    SER_STOP = 4'h8
  } uhi_ser_state_t;
endpackage : uhi_pkg

// File: uhi_channel.sv
// one serial channel: holding registers, fifos, start validation and interrupt masking
`timescale 1ns/10ps
`include "uhi_defs.svh"
module uhi_channel
  import uhi_pkg::*;
#(
  parameter int TICK_DIV = 54, // core clocks per 16x tick
  parameter int DEPTH = 16 // fifo depth, power of two
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire uhi_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic sin,
  output logic sout,
  input wire logic [3:0] modem_in,
  output logic chan_irq_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int TW = $clog2(TICK_DIV + 1);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // receive trigger level selected by the two fifo control bits
  function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
    logic [7:0] lv;
    unique case (sel)
      2'h0: lv = `UHI_TRIG0;
      2'h1: lv = `UHI_TRIG1;
      2'h2: lv = `UHI_TRIG2;
      2'h3: lv = `UHI_TRIG3;
    endcase
    return lv[CW-1:0];
  endfunction : trig_level

  // pointer step with wrap
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return p + {{(PW-1){1'b0}}, 1'b1};
  endfunction : ptr_inc

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] mask; // interrupt_mask_control low nibble
  logic [7:0] lctl; // line_control, only the latch bit steers logic here
  logic fifo_en; // fifo mode
  logic [1:0] trig_sel; // receive trigger choice
  logic ovr, frm, brk; // sticky line errors
  logic [3:0] mdelta; // modem change bits
  logic [3:0] mprev; // last modem inputs
  logic thre_pend; // transmit empty interrupt pending
  logic sin_prev; // for falling edge detect
  logic [TW-1:0] tick_cnt; // 16x divider
  uhi_rx_entry_t rx_mem [DEPTH];
  logic [PW-1:0] rx_wp, rx_rp;
  logic [CW-1:0] rx_cnt;
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] tx_wp, tx_rp;
  logic [CW-1:0] tx_cnt;
  uhi_ser_state_t rx_st, tx_st;
  logic [3:0] rx_sub, tx_sub; // tick position within a bit
  logic [2:0] rx_bit, tx_bit; // bit index
  logic [7:0] rx_sh; // rx_shift_stage
  logic [7:0] tx_sh; // tx_shift_stage

  // ----------------------------------------
  // host access decode
  // ----------------------------------------
  wire sel = !bus_req.cs_n;
  wire gen = sel && !lctl[`UHI_LCR_DLE]; // general set only with latch bit clear
  wire rd = bus_req.rd;
  wire wr = bus_req.wr;
  wire [2:0] a = bus_req.addr;
  wire wr_hold = gen && wr && a == `UHI_OFS_HOLD;
  wire rd_hold = gen && rd && a == `UHI_OFS_HOLD;
  wire wr_mask = gen && wr && a == `UHI_OFS_MASK;
  wire wr_fctl = gen && wr && a == `UHI_OFS_SRC_FCTL;
  wire rd_src = gen && rd && a == `UHI_OFS_SRC_FCTL;
  wire wr_lctl = sel && wr && a == `UHI_OFS_LCTL;
  wire rd_lstat = sel && rd && a == `UHI_OFS_LSTAT;
  wire rd_mstat = sel && rd && a == `UHI_OFS_MSTAT;

  // ----------------------------------------
  // fifo bookkeeping
  // ----------------------------------------
  // single mode behaves as a one-deep holding register
  wire [CW-1:0] cap = fifo_en ? CW'(DEPTH) : CW'(1);
  wire rx_full = rx_cnt == cap;
  wire tx_full = tx_cnt == cap;
  wire tx_push = wr_hold && !tx_full;
  wire tx_pop = tx_st == SER_IDLE && tx_cnt != '0;
  wire rx_pop = rd_hold && rx_cnt != '0;
  wire tick = tick_cnt == TW'(TICK_DIV - 1);
  wire rx_done = rx_st == SER_STOP && tick && rx_sub == `UHI_LAST_TICK;
  wire rx_push = rx_done && !rx_full;
  wire rx_ovr = rx_done && rx_full;
  wire new_frm = !sin;
  wire new_brk = !sin && rx_sh == 8'h00;
  wire fifo_rst = wr_fctl && bus_req.wdata[`UHI_FCR_EN] != fifo_en;
  wire rx_clr = fifo_rst || (wr_fctl && bus_req.wdata[`UHI_FCR_RXRST]);
  wire tx_clr = fifo_rst || (wr_fctl && bus_req.wdata[`UHI_FCR_TXRST]);
  wire tx_going_empty = tx_pop && tx_cnt == CW'(1) && !tx_push;

  // any error mark among the characters still queued
  logic q_err;
  always_comb begin
    logic [PW-1:0] off;
    q_err = 1'b0;
    off = '0;
    for (int i = 0; i < DEPTH; i++) begin
      off = PW'(i) - rx_rp;
      if (CW'(off) < rx_cnt && (rx_mem[i].brk || rx_mem[i].frm)) begin
        q_err = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // status words
  // ----------------------------------------
  wire tx_idle = tx_st == SER_IDLE;
  wire [7:0] lstat = {
    fifo_en && q_err,
    tx_cnt == '0 && tx_idle,
    tx_cnt == '0,
    brk, frm, 1'b0, ovr,
    rx_cnt != '0
  };
  wire [CW-1:0] trig = trig_level(trig_sel);
  wire rx_lvl = fifo_en ? rx_cnt >= trig : rx_cnt != '0;
  wire irq_line = mask[2] && (|lstat[4:1]);
  wire irq_rx = mask[0] && rx_lvl;
  wire irq_tx = mask[1] && thre_pend;
  wire irq_mdm = mask[3] && (|mdelta);
  // fixed priority: line errors, receive, transmit, modem
  wire [3:0] src_code = irq_line ? `UHI_SRC_LINE :
                        irq_rx ? `UHI_SRC_RX_READY_IRQ :
                        irq_tx ? `UHI_SRC_TXEMPTY :
                        irq_mdm ? `UHI_SRC_MODEM : `UHI_SRC_NONE;
  wire [7:0] src_word = {{2{fifo_en}}, 2'b00, src_code};
  // upper nibble of the mask register always reads zero
  wire [7:0] mask_word = {4'h0, mask};
  wire [7:0] mstat = {modem_in, mdelta};
  wire [7:0] next_rdata = rd_hold ? rx_mem[rx_rp].data :
                          (gen && a == `UHI_OFS_MASK) ? mask_word :
                          rd_src ? src_word :
                          (sel && a == `UHI_OFS_LCTL) ? lctl :
                          rd_lstat ? lstat :
                          rd_mstat ? mstat : 8'h00;
  wire next_irq = irq_line || irq_rx || irq_tx || irq_mdm;

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  // control registers written by the host
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask <= `UHI_MASK_RST;
      lctl <= `UHI_LCR_RST;
      fifo_en <= 1'b0;
      trig_sel <= 2'h0;
    end else begin
      if (wr_mask) begin
        mask <= bus_req.wdata[3:0];
      end
      if (wr_lctl) begin
        lctl <= bus_req.wdata;
      end
      if (wr_fctl) begin
        fifo_en <= bus_req.wdata[`UHI_FCR_EN];
        trig_sel <= bus_req.wdata[7:6];
      end
    end
  end

  // read data and interrupt pin come from flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= 8'h00;
      chan_irq_out <= 1'b0;
    end else begin
      if (sel && rd) begin
        bus_rdata <= next_rdata;
      end
      chan_irq_out <= next_irq;
    end
  end

  // sticky line errors, cleared by a status read; a new error wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovr <= 1'b0;
      frm <= 1'b0;
      brk <= 1'b0;
    end else begin
      ovr <= rx_ovr || (ovr && !rd_lstat);
      frm <= (rx_push && new_frm) || (frm && !rd_lstat);
      brk <= (rx_push && new_brk) || (brk && !rd_lstat);
    end
  end

  // modem change bits, cleared by a modem status read; a change wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mprev <= 4'h0;
      mdelta <= 4'h0;
    end else begin
      mprev <= modem_in;
      mdelta <= (modem_in ^ mprev) | (mdelta & {4{!rd_mstat}});
    end
  end

  // transmit empty pending: set on draining or on enabling while empty,
  // cleared by a source read that reports it or by new data; set wins
  wire thre_set = tx_going_empty || (wr_mask && bus_req.wdata[1] && !mask[1] && tx_cnt == '0);
  wire thre_clr = wr_hold || (rd_src && src_code == `UHI_SRC_TXEMPTY);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      thre_pend <= 1'b0;
    end else begin
      thre_pend <= thre_set || (thre_pend && !thre_clr);
    end
  end

  // ----------------------------------------
  // fifos
  // ----------------------------------------
  // transmit queue; a write to a full holding stage is dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else if (tx_clr) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) begin
        tx_wp <= ptr_inc(tx_wp);
      end
      if (tx_pop) begin
        tx_rp <= ptr_inc(tx_rp);
      end
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end

  // storage has no reset; a holding read with the receive queue empty still returns the slot at rx_rp
  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= bus_req.wdata;
    end
    if (rx_push) begin
      rx_mem[rx_wp] <= '{brk: new_brk, frm: new_frm, data: rx_sh};
    end
  end

  // receive queue; a character arriving when full is lost as overrun
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else if (rx_clr) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) begin
        rx_wp <= ptr_inc(rx_wp);
      end
      if (rx_pop) begin
        rx_rp <= ptr_inc(rx_rp);
      end
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // ----------------------------------------
  // 16x tick
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  // 8 data bits, one stop bit; start is revalidated at mid bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sin_prev <= 1'b1;
      rx_st <= SER_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
    end else begin
      sin_prev <= sin;
      unique case (rx_st)
        SER_IDLE: begin
          if (sin_prev && !sin) begin
            rx_st <= SER_START;
            rx_sub <= 4'h0;
          end
        end
        SER_START: begin
          if (tick && rx_sub == `UHI_MID_TICK) begin
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_st <= sin ? SER_IDLE : SER_DATA;
          end else if (tick) begin
            rx_sub <= rx_sub + 4'h1;
          end
        end
        SER_DATA: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `UHI_LAST_TICK) begin
              rx_sh <= {sin, rx_sh[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_st <= SER_STOP;
              end
            end
          end
        end
        SER_STOP: begin
          if (tick) begin
            rx_sub <= rx_sub + 4'h1;
          end
          if (rx_done) begin
            rx_st <= SER_IDLE;
          end
        end
        default: rx_st <= SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // loads the shift stage as soon as it is idle, then bits run on the tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_st <= SER_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      sout <= 1'b1;
    end else begin
      unique case (tx_st)
        SER_IDLE: begin
          sout <= 1'b1;
          if (tx_pop) begin
            tx_sh <= tx_mem[tx_rp];
            tx_st <= SER_START;
            tx_sub <= 4'h0;
            tx_bit <= 3'h0;
            sout <= 1'b0;
          end
        end
        SER_START, SER_DATA, SER_STOP: begin
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `UHI_LAST_TICK) begin
              if (tx_st == SER_STOP) begin
                tx_st <= SER_IDLE;
              end else if (tx_st == SER_START || tx_bit != 3'h7) begin
                sout <= tx_sh[0];
                tx_sh <= {1'b0, tx_sh[7:1]};
                tx_bit <= (tx_st == SER_START) ? 3'h0 : tx_bit + 3'h1;
                tx_st <= SER_DATA;
              end else begin
                sout <= 1'b1;
                tx_st <= SER_STOP;
              end
            end
          end
        end
        default: tx_st <= SER_IDLE;
      endcase
    end
  end
endmodule : uhi_channel

// File: uhi_channel_props.sv
// assertion checker bound to the serial channel ports
`timescale 1ns/10ps
`include "uhi_defs.svh"
module uhi_channel_chk
  import uhi_pkg::*;
#(
  parameter int TICK_DIV = 54, // core clocks per 16x tick
  parameter int DEPTH = 16 // fifo depth
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire uhi_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic sin,
  input wire logic sout,
  input wire logic [3:0] modem_in,
  input wire logic chan_irq_out
);
  // ----------------------------------------
  // shadows of host-written control bits
  // ----------------------------------------
  logic [3:0] mask_sh; // mirror of the interrupt mask
  logic dle_sh; // mirror of line control bit7
  logic fifo_sh; // mirror of fifo enable
  wire rd_go = !bus_req.cs_n && bus_req.rd; // read taken
  wire wr_go = !bus_req.cs_n && bus_req.wr; // write taken
  wire rd_stat = rd_go && bus_req.addr == `UHI_OFS_LSTAT; // status read
  // mirrors move on the same edge as the real registers, so no lag to allow for
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_sh <= 4'h0;
      dle_sh <= 1'b0;
      fifo_sh <= 1'b0;
    end else if (wr_go) begin
      if (bus_req.addr == `UHI_OFS_LCTL) dle_sh <= bus_req.wdata[7];
      if (!dle_sh && bus_req.addr == `UHI_OFS_MASK) mask_sh <= bus_req.wdata[3:0];
      if (!dle_sh && bus_req.addr == `UHI_OFS_SRC_FCTL) fifo_sh <= bus_req.wdata[0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // mask write and its read-back, one idle cycle apart as the host tasks do
  sequence mask_write_s;
    wr_go && !dle_sh && bus_req.addr == `UHI_OFS_MASK;
  endsequence
  sequence mask_read_s;
    rd_go && !dle_sh && bus_req.addr == `UHI_OFS_MASK;
  endsequence
  mask_readback_a:
    assert property (mask_write_s ##2 mask_read_s |=>
      bus_rdata[7:4] == 4'h0 && bus_rdata[3:0] == $past(bus_req.wdata[3:0], 3)) else $error("mask readback wrong");
  latch_block_a:
    assert property (rd_go && dle_sh && bus_req.addr < 3'h3 |=> bus_rdata == 8'h00) else $error("latched set leaked");
  status_tx_a:
    assert property (rd_stat |=> !bus_rdata[6] || bus_rdata[5]) else $error("bit6 set with queue busy");
  fifo_err_a:
    assert property (rd_stat && !fifo_sh |=> !bus_rdata[7]) else $error("bit7 outside fifo mode");
  polled_quiet_a:
    assert property (mask_sh == 4'h0 && $past(mask_sh) == 4'h0 |-> !chan_irq_out) else $error("irq with mask zero");
  modem_irq_a:
    assert property (mask_sh[3] && $changed(modem_in) |-> ##[1:4] chan_irq_out) else $error("modem change no irq");
  rx_irq_level_a:
    assert property (mask_sh == 4'h1 && !fifo_sh && rd_stat |=> bus_rdata[0] == chan_irq_out)
      else $error("rx irq differs from ready");
  tx_start_a:
    assert property ($fell(sout) |-> !sout [*8]) else $error("start bit too short");
  src_code_a:
    assert property (rd_go && !dle_sh && bus_req.addr == `UHI_OFS_SRC_FCTL |=>
      bus_rdata[3:0] inside {`UHI_SRC_NONE, `UHI_SRC_LINE, `UHI_SRC_RX_READY_IRQ, `UHI_SRC_TXEMPTY, `UHI_SRC_MODEM}
      && bus_rdata[5:4] == 2'h0 && bus_rdata[7:6] == {2{$past(fifo_sh)}}) else $error("source report malformed");
endmodule : uhi_channel_chk
bind uhi_channel uhi_channel_chk #(.TICK_DIV(TICK_DIV), .DEPTH(DEPTH)) chk_u (.core_clk(core_clk), .nrst(nrst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .sin(sin), .sout(sout), .modem_in(modem_in), .chan_irq_out(chan_irq_out));

// File: uhi_line_peer.sv
// serial line peer: sends frames to the channel and receives its frames
`timescale 1ns/10ps
module uhi_line_peer #(
  parameter int BIT_CLKS = 16 // core clocks per serial bit
) (
  input wire logic core_clk,
  input wire logic sout,
  output logic sin
);
  // ----------------------------------------
  // line driver and receiver
  // ----------------------------------------
  initial sin = 1'b1; // line idles high
  // start low, lsb first, caller picks the stop level to force framing faults
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= f[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    sin <= 1'b1;
    @(posedge core_clk);
  endtask : send
  // low pulse shorter than half a bit, then a quiet line
  task automatic glitch(input int n);
    sin <= 1'b0;
    repeat (n) @(posedge core_clk);
    sin <= 1'b1;
    repeat (BIT_CLKS * 10) @(posedge core_clk);
  endtask : glitch
  // bounded wait for a start bit, then mid-bit samples; ok low on timeout or bad stop
  task automatic catch_frame(output logic [7:0] b, output bit ok);
    ok = 1'b0;
    b = 8'h00;
    for (int t = 0; t < 200 && !ok; t++) begin
      @(negedge core_clk);
      ok = !sout;
    end
    repeat (BIT_CLKS / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(negedge core_clk);
      b[i] = sout;
    end
    repeat (BIT_CLKS) @(negedge core_clk);
    ok = ok && sout;
  endtask : catch_frame
endmodule : uhi_line_peer

// File: uhi_tb.sv
// self-checking bench for one serial channel
`timescale 1ns/10ps
module tb
  import uhi_pkg::*;
;
  // ----------------------------------------
  // clock, reset and design hookup
  // ----------------------------------------
  localparam int BIT_CLKS = 16; // one tick per clock, sixteen ticks a bit
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  uhi_bus_req_t bus_req = {1'b1, 13'h0000}; // idle bus
  logic [7:0] bus_rdata;
  logic sin;
  logic sout;
  logic [3:0] modem_in = 4'h0;
  logic chan_irq_out;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  uhi_channel #(.TICK_DIV(1), .DEPTH(16)) dut_u (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sin(sin), .sout(sout), .modem_in(modem_in), .chan_irq_out(chan_irq_out));
  uhi_line_peer #(.BIT_CLKS(BIT_CLKS)) peer_u (.core_clk(core_clk), .sout(sout), .sin(sin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // one write cycle, strobe held until the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= {1'b0, 1'b0, 1'b1, a, d};
    @(posedge core_clk);
    bus_req <= {1'b1, 13'h0000};
  endtask : wr
  // one read cycle; data lands on the taking edge, so look just after it
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= {1'b0, 1'b1, 1'b0, a, 8'h00};
    @(posedge core_clk);
    bus_req <= {1'b1, 13'h0000};
    #1 chk(bus_rdata, exp);
  endtask : rd
  // irq is registered, so give the cause a few edges to land
  task automatic irq_is(input logic v);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h00, chan_irq_out}, {7'h00, v});
  endtask : irq_is
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_regs;
    rd(3'h1, 8'h00);
    rd(3'h5, 8'h60);
    rd(3'h2, 8'h01);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h1, 8'h00);
    rd(3'h4, 8'h00);
    wr(3'h3, 8'h80);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h00);
  endtask : t_reset_regs
  task automatic t_tx;
    logic [7:0] b;
    bit ok;
    wr(3'h0, 8'hA5);
    peer_u.catch_frame(b, ok);
    if (!ok) begin
      error_cnt++;
      print_verdict();
    end
    chk(b, 8'hA5);
    repeat (BIT_CLKS) @(posedge core_clk);
    rd(3'h5, 8'h60);
    wr(3'h1, 8'h02);
    irq_is(1'b1);
    rd(3'h2, 8'h02);
    irq_is(1'b0);
    wr(3'h1, 8'h00);
  endtask : t_tx
  task automatic t_rx_single;
    wr(3'h1, 8'h01);
    peer_u.send(8'h3C, 1'b1);
    irq_is(1'b1);
    rd(3'h2, 8'h04);
    rd(3'h5, 8'h61);
    rd(3'h0, 8'h3C);
    irq_is(1'b0);
    rd(3'h5, 8'h60);
  endtask : t_rx_single
  task automatic t_false_start;
    peer_u.glitch(4);
    rd(3'h5, 8'h60);
    irq_is(1'b0);
    wr(3'h1, 8'h08);
    @(posedge core_clk);
    modem_in <= 4'h9;
    irq_is(1'b1);
    rd(3'h6, 8'h99);
    irq_is(1'b0);
  endtask : t_false_start
  task automatic t_line_err;
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h04);
    peer_u.send(8'h00, 1'b0);
    irq_is(1'b1);
    rd(3'h2, 8'hC6);
    rd(3'h5, 8'hF9);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h60);
    irq_is(1'b0);
  endtask : t_line_err
  task automatic t_fifo_trig;
    wr(3'h2, 8'h41);
    wr(3'h1, 8'h01);
    for (int i = 1; i < 4; i++) peer_u.send(8'(i), 1'b1);
    irq_is(1'b0);
    rd(3'h2, 8'hC1);
    peer_u.send(8'h04, 1'b1);
    irq_is(1'b1);
    rd(3'h2, 8'hC4);
    rd(3'h0, 8'h01);
    irq_is(1'b0);
    for (int i = 5; i < 19; i++) peer_u.send(8'(i), 1'b1);
    rd(3'h5, 8'h63);
    for (int i = 2; i < 18; i++) rd(3'h0, 8'(i));
    rd(3'h5, 8'h60);
    wr(3'h1, 8'h00);
  endtask : t_fifo_trig
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_regs();
    t_tx();
    t_rx_single();
    t_false_start();
    t_line_err();
    t_fifo_trig();
    print_verdict();
  end
endmodule : tb
